// [src/pdf_front_end.v]
// Pixel input front end of a colour palette converter with a Wishbone register slave.
`timescale 1ns/1ns
`default_nettype none
`include "pdf_regs.vh"

module pdf_front_end #(
  parameter NUM_PIX = 5,
  parameter DEPTH   = `PDF_FIFO_DEPTH,
  parameter AW      = 3
) (
  // Clock and reset.
  input  wire                    clk_i,
  input  wire                    rst_i,
  // Wishbone slave.
  input  wire                    cyc_i,
  input  wire                    stb_i,
  input  wire                    we_i,
  input  wire [7:0]              adr_i,
  input  wire [3:0]              sel_i,
  input  wire [31:0]             dat_i,
  output reg  [31:0]             dat_o,
  output reg                     ack_o,
  // Pixel input ports, four per pixel: red, green, blue, pseudo.
  input  wire [32*NUM_PIX-1:0]   pix_i,
  input  wire [NUM_PIX-1:0]      pixel_source_select_i,
  input  wire [2*NUM_PIX-1:0]    overlay_i,
  input  wire                    blank_n_i,
  input  wire                    hsync_n_i,
  input  wire                    vsync_n_i,
  input  wire                    pix_valid_i,
  output wire                    pix_ready_o,
  // Converter side.
  output reg  [7:0]              dac_red_o,
  output reg  [7:0]              dac_green_o,
  output reg  [7:0]              dac_blue_o,
  output reg                     dot_valid_o,
  output reg                     blank_ped_cut_o,
  output reg                     sync_cut_o
);

  localparam FW = `PDF_PIX_FIELD_W;
  localparam WW = NUM_PIX * FW + 3;

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  reg [7:0]                  pseudo_mask_r;
  reg [1:0]                  ovl_mask_r;
  reg [`PDF_DAC_CTRL_W-1:0]  dac_ctrl_r;
  reg [`PDF_PIX_MODE_W-1:0]  pix_mode_r;
  reg [`PDF_COMPOSITE_W-1:0] composite_r;
  reg [23:0]                 ovl_colour_r [1:3];
  reg [`PDF_SUM_W-1:0]       sum_r [0:2];

  wire                       fifo_empty;
  wire                       fifo_full;
  wire                       wr_en;

  // Byte-lane merge for a 32-bit word under sel.
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer      b;
    begin
      lane_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          lane_merge[8*b +: 8] = new_v[8*b +: 8];
        end
      end
    end
  endfunction

  // The write lands at the edge where the master sees ack.
  assign wr_en = cyc_i && stb_i && we_i && ack_o;

  // Merged overlay colour words, so each byte lane can be written on its own.
  wire [31:0]                ovl_wr1;
  wire [31:0]                ovl_wr2;
  wire [31:0]                ovl_wr3;

  assign ovl_wr1 = lane_merge({8'h00, ovl_colour_r[1]}, dat_i, sel_i);
  assign ovl_wr2 = lane_merge({8'h00, ovl_colour_r[2]}, dat_i, sel_i);
  assign ovl_wr3 = lane_merge({8'h00, ovl_colour_r[3]}, dat_i, sel_i);

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o           <= 1'b0;
      dat_o           <= 32'h00000000;
      pseudo_mask_r   <= `PDF_RST_PSEUDO_MASK;
      ovl_mask_r      <= `PDF_RST_OVL_MASK;
      dac_ctrl_r      <= `PDF_RST_DAC_CTRL;
      pix_mode_r      <= `PDF_RST_PIX_MODE;
      composite_r     <= `PDF_RST_COMPOSITE;
      ovl_colour_r[1] <= `PDF_RST_OVL_COLOUR;
      ovl_colour_r[2] <= `PDF_RST_OVL_COLOUR;
      ovl_colour_r[3] <= `PDF_RST_OVL_COLOUR;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      if (cyc_i && stb_i && !ack_o) begin
        case (adr_i)
          `PDF_ADDR_PSEUDO_MASK: dat_o <= {24'h000000, pseudo_mask_r};
          `PDF_ADDR_OVL_MASK:    dat_o <= {30'h00000000, ovl_mask_r};
          `PDF_ADDR_DAC_CTRL:    dat_o <= {27'h0000000, dac_ctrl_r};
          `PDF_ADDR_PIX_MODE:    dat_o <= {25'h0000000, pix_mode_r};
          `PDF_ADDR_COMPOSITE:   dat_o <= {30'h00000000, composite_r};
          `PDF_ADDR_OVL_COLOUR1: dat_o <= {8'h00, ovl_colour_r[1]};
          `PDF_ADDR_OVL_COLOUR2: dat_o <= {8'h00, ovl_colour_r[2]};
          `PDF_ADDR_OVL_COLOUR3: dat_o <= {8'h00, ovl_colour_r[3]};
          `PDF_ADDR_SUM_RED:     dat_o <= {8'h00, sum_r[0]};
          `PDF_ADDR_SUM_GREEN:   dat_o <= {8'h00, sum_r[1]};
          `PDF_ADDR_SUM_BLUE:    dat_o <= {8'h00, sum_r[2]};
          `PDF_ADDR_STATUS:      dat_o <= {30'h00000000, fifo_full, fifo_empty};
          default:               dat_o <= 32'h00000000;
        endcase
      end
      if (wr_en) begin
        case (adr_i)
          `PDF_ADDR_PSEUDO_MASK: if (sel_i[0]) pseudo_mask_r <= dat_i[7:0];
          `PDF_ADDR_OVL_MASK:    if (sel_i[0]) ovl_mask_r <= dat_i[1:0];
          `PDF_ADDR_DAC_CTRL:    if (sel_i[0]) dac_ctrl_r <= dat_i[`PDF_DAC_CTRL_W-1:0];
          `PDF_ADDR_PIX_MODE:    if (sel_i[0]) pix_mode_r <= dat_i[`PDF_PIX_MODE_W-1:0];
          `PDF_ADDR_COMPOSITE:   if (sel_i[0]) composite_r <= dat_i[`PDF_COMPOSITE_W-1:0];
          `PDF_ADDR_OVL_COLOUR1: ovl_colour_r[1] <= ovl_wr1[23:0];
          `PDF_ADDR_OVL_COLOUR2: ovl_colour_r[2] <= ovl_wr2[23:0];
          `PDF_ADDR_OVL_COLOUR3: ovl_colour_r[3] <= ovl_wr3[23:0];
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input sampling into the FIFO.

  reg  [WW-1:0] in_word;
  wire [WW-1:0] head_word;
  wire          head_valid;
  wire          head_pop;
  integer       k;

  // Blank and both syncs ride in the same word as the pixels.
  always @* begin
    in_word = {WW{1'b0}};
    for (k = 0; k < NUM_PIX; k = k + 1) begin
      in_word[k*FW +: 32]    = pix_i[32*k +: 32];
      in_word[k*FW+32 +: 2]  = overlay_i[2*k +: 2];
      in_word[k*FW+34]       = pixel_source_select_i[k];
    end
    in_word[WW-3] = blank_n_i;
    in_word[WW-2] = hsync_n_i;
    in_word[WW-1] = vsync_n_i;
  end

  // A full FIFO stalls the controller through pix_ready_o.
  pdf_fifo #(
    .WIDTH (WW),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   (in_word),
    .in_valid_i  (pix_valid_i),
    .in_ready_o  (pix_ready_o),
    .out_data_o  (head_word),
    .out_valid_o (head_valid),
    .out_ready_i (head_pop),
    .empty_o     (fifo_empty),
    .full_o      (fifo_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Dot serialiser: one pixel of the head word per clock.

  // Pixels per input clock, held to the range 2 to NUM_PIX.
  function [2:0] dots_per_clk;
    input [`PDF_MODE_COUNT_W-1:0] req;
    begin
      if (req < 3'd2) begin
        dots_per_clk = 3'd2;
      end else if (req > NUM_PIX[2:0]) begin
        dots_per_clk = NUM_PIX[2:0];
      end else begin
        dots_per_clk = req;
      end
    end
  endfunction

  reg        state_r;
  reg [2:0]  dot_idx_r;
  reg [2:0]  dot_idx_nxt;
  reg        state_nxt;
  wire [2:0] dot_cnt;

  assign dot_cnt  = dots_per_clk(pix_mode_r[`PDF_MODE_COUNT_LSB +: `PDF_MODE_COUNT_W]);
  assign head_pop = head_valid && (dot_idx_r == dot_cnt - 3'd1);

  always @* begin
    state_nxt   = state_r;
    dot_idx_nxt = dot_idx_r;
    case (state_r)
      ST_IDLE: begin
        dot_idx_nxt = 3'd0;
        if (head_valid) begin
          // Pixel 0 is shown in this cycle, so the next dot is pixel 1.
          state_nxt   = ST_RUN;
          dot_idx_nxt = 3'd1;
        end
      end
      ST_RUN: begin
        if (head_pop) begin
          dot_idx_nxt = 3'd0;
        end else if (head_valid) begin
          dot_idx_nxt = dot_idx_r + 3'd1;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt   = ST_IDLE;
        dot_idx_nxt = 3'd0;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r   <= ST_IDLE;
      dot_idx_r <= 3'd0;
    end else begin
      state_r   <= state_nxt;
      dot_idx_r <= dot_idx_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Colour selection for the current dot.

  wire [FW-1:0] cur_pix;
  wire [7:0]    pseudo_masked;
  wire [1:0]    ovl_masked;
  wire          cur_blank_n;
  wire          cur_hsync_n;
  wire          cur_vsync_n;
  reg           use_pseudo;
  reg  [23:0]   colour;

  assign cur_pix       = head_word[dot_idx_r*FW +: FW];
  assign pseudo_masked = cur_pix[31:24] & pseudo_mask_r;
  assign ovl_masked    = cur_pix[33:32] & ovl_mask_r;
  assign cur_blank_n   = head_word[WW-3];
  assign cur_hsync_n   = head_word[WW-2];
  assign cur_vsync_n   = head_word[WW-1];

  // Without the palette tables the pseudo path shows the masked index as grey.
  always @* begin
    if (!pix_mode_r[`PDF_MODE_32BIT_BIT]) begin
      use_pseudo = 1'b1;
    end else if (composite_r[`PDF_COMP_COMPARE_BIT]) begin
      use_pseudo = (pseudo_masked != 8'h00);
    end else begin
      use_pseudo = cur_pix[34];
    end
    if (!cur_blank_n) begin
      colour = 24'h000000;
    end else if (ovl_masked != 2'b00) begin
      colour = ovl_colour_r[ovl_masked];
    end else if (use_pseudo) begin
      colour = {pseudo_masked, pseudo_masked, pseudo_masked};
    end else begin
      colour = cur_pix[23:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter outputs and checksums.

  reg vsync_prev_r;
  integer c;

  always @(posedge clk_i) begin
    if (rst_i) begin
      dac_red_o       <= 8'h00;
      dac_green_o     <= 8'h00;
      dac_blue_o      <= 8'h00;
      dot_valid_o     <= 1'b0;
      blank_ped_cut_o <= 1'b0;
      sync_cut_o      <= 1'b0;
    end else begin
      dot_valid_o     <= head_valid;
      // An empty queue shows zero rather than unwritten storage.
      dac_red_o       <= head_valid ? colour[7:0] : 8'h00;
      dac_green_o     <= head_valid ? colour[15:8] : 8'h00;
      dac_blue_o      <= head_valid ? colour[23:16] : 8'h00;
      blank_ped_cut_o <= head_valid && !cur_blank_n &&
                         dac_ctrl_r[`PDF_DAC_BLANK_PED_BIT];
      sync_cut_o      <= head_valid && (!cur_hsync_n || !cur_vsync_n) &&
                         dac_ctrl_r[`PDF_DAC_COMP_SYNC_BIT];
    end
  end

  // A clearing dot that is itself unblanked starts the new sum.
  always @(posedge clk_i) begin
    if (rst_i) begin
      vsync_prev_r <= 1'b1;
      for (c = 0; c < 3; c = c + 1) begin
        sum_r[c] <= {`PDF_SUM_W{1'b0}};
      end
    end else if (head_valid) begin
      vsync_prev_r <= cur_vsync_n;
      for (c = 0; c < 3; c = c + 1) begin
        if (cur_vsync_n && !vsync_prev_r) begin
          sum_r[c] <= cur_blank_n ? {16'h0000, colour[8*c +: 8]}
                                  : {`PDF_SUM_W{1'b0}};
        end else if (cur_blank_n) begin
          sum_r[c] <= sum_r[c] + {16'h0000, colour[8*c +: 8]};
        end
      end
    end
  end

endmodule

`default_nettype wire

// [shared/pdf_regs.vh]
// Register offsets, field positions and reset values of the palette pixel front end.
`ifndef PDF_REGS_VH
`define PDF_REGS_VH

// Wishbone byte addresses, one aligned 32-bit word per register.
`define PDF_ADDR_PSEUDO_MASK   8'h00
`define PDF_ADDR_OVL_MASK      8'h04
`define PDF_ADDR_DAC_CTRL      8'h08
`define PDF_ADDR_PIX_MODE      8'h0C
`define PDF_ADDR_COMPOSITE     8'h10
`define PDF_ADDR_OVL_COLOUR1   8'h14
`define PDF_ADDR_OVL_COLOUR2   8'h18
`define PDF_ADDR_OVL_COLOUR3   8'h1C
`define PDF_ADDR_SUM_RED       8'h20
`define PDF_ADDR_SUM_GREEN     8'h24
`define PDF_ADDR_SUM_BLUE      8'h28
`define PDF_ADDR_STATUS        8'h2C

// DAC control fields.
`define PDF_DAC_BLANK_PED_BIT  0
`define PDF_DAC_COMP_SYNC_BIT  1
`define PDF_DAC_CTRL_W         5

// Pixel mode fields: pixels per input clock and 32-bit pixel mode.
`define PDF_MODE_COUNT_LSB     0
`define PDF_MODE_COUNT_W       3
`define PDF_MODE_32BIT_BIT     3
`define PDF_PIX_MODE_W         7

// Compositing control: compare mode when set, select pins when clear.
`define PDF_COMP_COMPARE_BIT   0
`define PDF_COMPOSITE_W        2

// Status fields.
`define PDF_STAT_EMPTY_BIT     0
`define PDF_STAT_FULL_BIT      1

// Reset values.
`define PDF_RST_PSEUDO_MASK    8'hFF
`define PDF_RST_OVL_MASK       2'h0
`define PDF_RST_DAC_CTRL       5'h00
`define PDF_RST_PIX_MODE       7'h0A
`define PDF_RST_COMPOSITE      2'h0
`define PDF_RST_OVL_COLOUR     24'h000000

// Widths of the data path.
`define PDF_SUM_W              24
`define PDF_PIX_FIELD_W        35
`define PDF_FIFO_DEPTH         8

`endif

// [src/pdf_fifo.v]
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none

module pdf_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset.
  input  wire             clk_i,
  input  wire             rst_i,
  // Fill side.
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  // Drain side.
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  // Status.
  output wire             empty_o,
  output wire             full_o
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW:0]      wr_ptr_r;
  reg [AW:0]      rd_ptr_r;
  wire            push;
  wire            pop;

  // The extra pointer bit tells a full buffer from an empty one.
  assign empty_o     = (wr_ptr_r == rd_ptr_r);
  assign full_o      = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                       (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign in_ready_o  = !full_o;
  assign out_valid_o = !empty_o;
  assign out_data_o  = mem_r[rd_ptr_r[AW-1:0]];
  assign push        = in_valid_i && !full_o;
  assign pop         = out_ready_i && !empty_o;

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  // Storage needs no reset; the pointers keep stale words unread.
  always @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

endmodule

`default_nettype wire

// [sim/pdf_front_end_monitor.sv]
// Concurrent checks on the ports of the pixel front end.
`timescale 1ns/1ns
`default_nettype none
module pdf_front_end_monitor (
  // Clock, reset and bus handshake.
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  // Pixel stream and converter codes.
  input wire logic       pix_valid_i,
  input wire logic       dot_valid_o,
  input wire logic [7:0] dac_red_o,
  input wire logic [7:0] dac_green_o,
  input wire logic [7:0] dac_blue_o,
  input wire logic       blank_ped_cut_o,
  input wire logic       sync_cut_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  // A low dot_valid_o with the word, together with the last quiet cycle before it, guarantees an empty queue, so the latency is exact.
  sequence s_quiet;
    !pix_valid_i [*2] ##1 (pix_valid_i && !dot_valid_o);
  endsequence
  ////////////////////////////////////////////////////////////
  a_ack_answer: assert property (s_req |=> ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_lone: assert property (s_req ##1 ack_o |=> !ack_o [*2])
    else $error("ack repeated after the master released");
  a_ack_unasked: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without a request");
  a_dot_latency: assert property (s_quiet |=> !dot_valid_o ##1 dot_valid_o)
    else $error("first dot not two edges after the word");
  a_dot_pairs: assert property ($rose(dot_valid_o) |-> dot_valid_o [*2])
    else $error("word shown as fewer than two dots");
  a_blank_zero: assert property (blank_ped_cut_o |-> dot_valid_o
    && {dac_red_o, dac_green_o, dac_blue_o} == 24'h000000)
    else $error("blanked dot with nonzero colour");
  a_sync_dot: assert property (sync_cut_o |-> dot_valid_o)
    else $error("sync offset cut outside a dot");
endmodule

bind pdf_front_end pdf_front_end_monitor i_pdf_front_end_monitor (.clk_i, .rst_i, .cyc_i,
  .stb_i, .ack_o, .pix_valid_i, .dot_valid_o, .dac_red_o, .dac_green_o, .dac_blue_o,
  .blank_ped_cut_o, .sync_cut_o);
`default_nettype wire

// [sim/pdf_pix_source.sv]
// Behavioural frame buffer that offers pixel words to the front end.
`timescale 1ns/1ns
`default_nettype none
module pdf_pix_source (
  // Clock and flow control.
  input  wire logic         clk_i,
  input  wire logic         pix_ready_i,
  // Pixel word.
  output var  logic [159:0] pix_o,
  output var  logic [4:0]   sel_o,
  output var  logic [9:0]   ovl_o,
  output var  logic         blank_n_o,
  output var  logic         hsync_n_o,
  output var  logic         vsync_n_o,
  output var  logic         valid_o
);
  int stall_cnt = 0;
  initial begin
    pix_o = 160'h0;
    sel_o = 5'h00;
    ovl_o = 10'h000;
    blank_n_o = 1'b1;
    hsync_n_o = 1'b1;
    vsync_n_o = 1'b1;
    valid_o = 1'b0;
  end
  // Entered just after an edge; the word is held until the edge that takes it.
  task automatic send(input logic [159:0] px, input logic [4:0] sl, input logic [9:0] ov,
                      input logic b, input logic h, input logic v);
    pix_o <= px;
    sel_o <= sl;
    ovl_o <= ov;
    blank_n_o <= b;
    hsync_n_o <= h;
    vsync_n_o <= v;
    valid_o <= 1'b1;
    @(posedge clk_i);
    while (pix_ready_i !== 1'b1) begin
      stall_cnt++;
      @(posedge clk_i);
    end
  endtask
  // A released bus shows inverted data so a stale word cannot pass for a fresh one.
  task automatic idle();
    valid_o <= 1'b0;
    pix_o <= ~pix_o;
    sel_o <= ~sel_o;
    ovl_o <= ~ovl_o;
  endtask
endmodule
`default_nettype wire

// [sim/pdf_front_end_bench.sv]
// Self-checking bench for the pixel front end.
`timescale 1ns/1ns
`default_nettype none
module pdf_front_end_bench;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc_i = 1'b0;
  logic         stb_i = 1'b0;
  logic         we_i = 1'b0;
  logic [7:0]   adr_i = 8'h00;
  logic [31:0]  dat_i = 32'h00000000;
  wire  [31:0]  dat_o;
  wire          ack_o, pix_ready_o, dot_valid_o, blank_ped_cut_o, sync_cut_o;
  wire  [7:0]   dac_red_o, dac_green_o, dac_blue_o;
  wire  [159:0] pix_i;
  wire  [4:0]   pixel_source_select_i;
  wire  [9:0]   overlay_i;
  wire          blank_n_i, hsync_n_i, vsync_n_i, pix_valid_i;
  int           bad_count = 0;
  int           cmp_count = 0;
  logic [25:0]  got[$];
  logic [25:0]  exp_q[$];
  logic [7:0]   pm = 8'hFF;
  logic [1:0]   om = 2'h0;
  logic [1:0]   dac = 2'h0;
  logic [6:0]   mode = 7'h0A;
  logic         cmpm = 1'b0;
  logic [23:0]  oc[1:3] = '{24'h000000, 24'h000000, 24'h000000};
  logic [23:0]  sum[3] = '{24'h000000, 24'h000000, 24'h000000};
  logic         prev_vs = 1'b1;
  logic [31:0]  rd;

  always #10 clk_i = ~clk_i;

  pdf_front_end #(.NUM_PIX(5), .DEPTH(8), .AW(3)) i_pdf_front_end (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .pix_i, .pixel_source_select_i,
    .overlay_i, .blank_n_i, .hsync_n_i, .vsync_n_i, .pix_valid_i, .pix_ready_o, .dac_red_o,
    .dac_green_o, .dac_blue_o, .dot_valid_o, .blank_ped_cut_o, .sync_cut_o);
  pdf_pix_source i_pdf_pix_source (.clk_i, .pix_ready_i(pix_ready_o), .pix_o(pix_i),
    .sel_o(pixel_source_select_i), .ovl_o(overlay_i), .blank_n_o(blank_n_i),
    .hsync_n_o(hsync_n_i), .vsync_n_o(vsync_n_i), .valid_o(pix_valid_i));

  always @(posedge clk_i) begin
    if (dot_valid_o === 1'b1)
      got.push_back({blank_ped_cut_o, sync_cut_o, dac_red_o, dac_green_o, dac_blue_o});
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
    case (a)
      8'h00: pm = d[7:0];
      8'h04: om = d[1:0];
      8'h08: dac = d[1:0];
      8'h0C: mode = d[6:0];
      8'h10: cmpm = d[0];
      8'h14: oc[1] = d[23:0];
      8'h18: oc[2] = d[23:0];
      8'h1C: oc[3] = d[23:0];
      default: ;
    endcase
  endtask
  function automatic logic [159:0] pw(input logic [7:0] s);
    for (int k = 0; k < 5; k++)
      pw[32*k +: 32] = {s ^ 8'hF0, s + 8'h40, s + 8'h20, s} + 32'h01010101 * k;
  endfunction
  // Works out the dots of a word under the present settings, then offers it.
  task automatic put(input logic [159:0] px, input logic [4:0] sl, input logic [9:0] ov,
                     input logic b, input logic h, input logic v);
    int n;
    logic [7:0] ps, r, g, bl;
    logic [1:0] o;
    n = mode[2:0] < 2 ? 2 : (mode[2:0] > 5 ? 5 : mode[2:0]);
    for (int k = 0; k < n; k++) begin
      ps = px[32*k+24 +: 8] & pm;
      o = ov[2*k +: 2] & om;
      {bl, g, r} = px[32*k +: 24];
      if (!b) {bl, g, r} = 24'h000000;
      else if (o != 2'h0) {bl, g, r} = oc[o];
      else if (!mode[3] || (cmpm ? ps != 8'h00 : sl[k])) {bl, g, r} = {ps, ps, ps};
      exp_q.push_back({!b && dac[0], (!h || !v) && dac[1], r, g, bl});
      if (!prev_vs && v) foreach (sum[i]) sum[i] = 24'h000000;
      if (b) begin
        sum[0] += r;
        sum[1] += g;
        sum[2] += bl;
      end
      prev_vs = v;
    end
    i_pdf_pix_source.send(px, sl, ov, b, h, v);
  endtask
  task automatic drain();
    int t;
    t = 0;
    i_pdf_pix_source.idle();
    while (got.size() < exp_q.size() && t < 500) begin
      @(posedge clk_i);
      t++;
    end
    chk(got.size(), exp_q.size());
    foreach (exp_q[i]) chk(got[i], exp_q[i]);
    got.delete();
    exp_q.delete();
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] a[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h2C, 8'h40};
    logic [31:0] e[9] = '{32'hFF, 32'h0, 32'h0, 32'h0A, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
    foreach (a[i]) begin
      wb(1'b0, a[i], 32'h00000000);
      chk(rd, e[i]);
    end
    wr(8'h40, 32'h12345678);
    wb(1'b0, 8'h40, 32'h00000000);
    chk(rd, 32'h00000000);
  endtask
  task automatic t_select();
    put(pw(8'h10), 5'h02, 10'h000, 1'b1, 1'b1, 1'b1);
    put(pw(8'h50), 5'h01, 10'h000, 1'b1, 1'b1, 1'b1);
    drain();
  endtask
  task automatic t_compare();
    wr(8'h10, 32'h00000001);
    wr(8'h00, 32'h0000000F);
    wb(1'b0, 8'h00, 32'h00000000);
    chk(rd, 32'h0000000F);
    put(pw(8'h00), 5'h01, 10'h000, 1'b1, 1'b1, 1'b1);
    drain();
    wr(8'h10, 32'h00000000);
    wr(8'h00, 32'h000000FF);
  endtask
  task automatic t_modes();
    logic [6:0] m[6] = '{7'h02, 7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h09};
    foreach (m[i]) begin
      wr(8'h0C, {25'h0, m[i]});
      put(pw(8'h33), 5'h05, 10'h000, 1'b1, 1'b1, 1'b1);
      drain();
    end
  endtask
  task automatic t_overlay();
    logic [1:0] m[3] = '{2'h2, 2'h3, 2'h0};
    wr(8'h0C, 32'h0000000D);
    wr(8'h14, 32'h00A1B2C3);
    wr(8'h18, 32'h00D4E5F6);
    wr(8'h1C, 32'h00170829);
    foreach (m[i]) begin
      wr(8'h04, {30'h0, m[i]});
      put(pw(8'h66), 5'h00, 10'h393, 1'b1, 1'b1, 1'b1);
      drain();
    end
  endtask
  task automatic t_blank();
    wr(8'h08, 32'h00000003);
    put(pw(8'h21), 5'h00, 10'h3FF, 1'b0, 1'b1, 1'b1);
    put(pw(8'h42), 5'h00, 10'h000, 1'b1, 1'b0, 1'b1);
    put(pw(8'h63), 5'h00, 10'h000, 1'b1, 1'b1, 1'b0);
    put(pw(8'h84), 5'h00, 10'h000, 1'b1, 1'b1, 1'b1);
    drain();
    wr(8'h08, 32'h00000000);
    put(pw(8'hA5), 5'h00, 10'h000, 1'b0, 1'b0, 1'b0);
    drain();
  endtask
  task automatic t_sum();
    put(pw(8'h11), 5'h00, 10'h000, 1'b1, 1'b1, 1'b0);
    put(pw(8'h9C), 5'h00, 10'h000, 1'b1, 1'b1, 1'b1);
    put(pw(8'hE7), 5'h00, 10'h000, 1'b0, 1'b1, 1'b1);
    put(pw(8'h3D), 5'h00, 10'h000, 1'b1, 1'b1, 1'b1);
    drain();
    for (int c = 0; c < 3; c++) begin
      wb(1'b0, 8'h20 + 8'h04 * c, 32'h00000000);
      chk(rd, {8'h00, sum[c]});
    end
  endtask
  task automatic t_fifo();
    int s;
    s = i_pdf_pix_source.stall_cnt;
    for (int i = 0; i < 12; i++) put(pw(8'(7 * i)), 5'h15, 10'h000, 1'b1, 1'b1, 1'b1);
    chk(i_pdf_pix_source.stall_cnt > s, 1);
    drain();
    wb(1'b0, 8'h2C, 32'h00000000);
    chk(rd, 32'h00000001);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_select();
    t_compare();
    t_modes();
    t_overlay();
    t_blank();
    t_sum();
    t_fifo();
    complete_run();
  end
endmodule
`default_nettype wire
